// File: hdl/pbc_pkg.sv
// Constants and types of the polling bit-check controller.
// Assumes a single 40 MHz system clock; no bus, all settings are plain ports.
//
// Functional notes
// - Base tick from crystal by divide 28/30
// - Extended tick is 4, 2 or 1 base ticks
// - Cycle sleep, warm-up, validation; fail returns sleep
// - Processing off in sleep, on in warm-up
// - Awake flag shows active versus sleeping
// - Sleep time is idle*stretch*1024 base ticks
// - Stretch is 1, or 8 with long idle
// - Maximum idle setting sleeps until changed
// - Measure edge intervals against programmable window
// - Bit count 0,3,6,9 gives double checks
// - All checks pass: receive, route data out
// - Interval outside window aborts to sleep
// - Window low*xtick, high minus one *xtick
// - Low and high bounds are 5-bit fields
// - Ignore data in warm-up; count each xtick
// - Fail below low at edge, at high immediately
// - Idle setting 31 means permanent sleep
// - Receive holds until commanded back to polling
// - Force pin low skips sleep, keeps settings
package pbc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned DIV_RATIO_A      = 28;
    localparam int unsigned DIV_RATIO_B      = 30;
    localparam int unsigned SLEEP_UNIT_TICKS = 1024;
    localparam int unsigned STRETCH_LONG     = 8;
    localparam int unsigned STRETCH_SHORT    = 1;
    localparam int unsigned XTICK_SLOW       = 4;
    localparam int unsigned XTICK_MID        = 2;
    localparam int unsigned XTICK_FAST       = 1;
    localparam int unsigned WARMUP_TICKS     = 64;
    localparam logic [4:0]  IDLE_PERMANENT   = 5'h1F;

    // ------------------------------------------------------------
    // Field widths and encodings
    // ------------------------------------------------------------
    localparam int unsigned IDLE_W  = 5;
    localparam int unsigned BOUND_W = 5;
    localparam int unsigned CNT_W   = 6;
    localparam int unsigned PASS_W  = 5;

    typedef enum logic [1:0] {
        PBC_BR_SLOW = 2'b00,
        PBC_BR_MID  = 2'b01,
        PBC_BR_FAST = 2'b10
    } pbc_baud_t;

    typedef enum logic [1:0] {
        PBC_SLEEP  = 2'b00,
        PBC_WARMUP = 2'b01,
        PBC_CHECK  = 2'b10,
        PBC_RECV   = 2'b11
    } pbc_state_t;

endpackage

// File: hdl/pbc_controller.sv
// Polling bit-check controller: sleep, warm-up, interval validation, receive.
// Assumes all inputs synchronous to clock_i; clock_i stands in for the crystal.
`timescale 1ns/1ps

module pbc_controller #(
    parameter int unsigned DIV_RATIO = pbc_pkg::DIV_RATIO_A,
    parameter int unsigned WARMUP    = pbc_pkg::WARMUP_TICKS
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // Configuration
    input  wire logic [4:0]  idle_setting_i,
    input  wire logic        long_idle_select_bit_i,
    input  wire logic [1:0]  baud_range_select_i,
    input  wire logic [1:0]  verified_bits_i,
    input  wire logic [4:0]  low_bound_i,
    input  wire logic [4:0]  high_bound_i,
    // Control
    input  wire logic        force_receive_n_i,
    input  wire logic        return_to_polling_i,
    // Signal path
    input  wire logic        demod_i,
    output logic             data_o,
    output logic             processing_en_o,
    // Status
    output logic             receiver_awake_flag_o,
    output logic             receive_mode_o
);

    // ------------------------------------------------------------
    // Base and extended tick
    // ------------------------------------------------------------
    logic [4:0] base_div;
    logic       base_tick;
    logic [1:0] ext_div;
    logic [1:0] ext_last;
    logic       ext_tick;

    assign base_tick = (base_div == 5'(DIV_RATIO - 1));

    assign ext_last = (baud_range_select_i == pbc_pkg::PBC_BR_SLOW) ? 2'(pbc_pkg::XTICK_SLOW - 1) :
                      (baud_range_select_i == pbc_pkg::PBC_BR_MID)  ? 2'(pbc_pkg::XTICK_MID - 1)
                                                                     : 2'(pbc_pkg::XTICK_FAST - 1);
    assign ext_tick = base_tick && (ext_div == ext_last);

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || base_tick) begin
            base_div <= 5'h0;
        end else begin
            base_div <= base_div + 5'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ext_div <= 2'h0;
        end else if (base_tick) begin
            ext_div <= (ext_div >= ext_last) ? 2'h0 : ext_div + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // State and counters
    // ------------------------------------------------------------
    pbc_pkg::pbc_state_t state;
    pbc_pkg::pbc_state_t next_state;
    logic [17:0] sleep_cnt;
    logic [17:0] sleep_target;
    logic [3:0]  stretch;
    logic [15:0] warm_cnt;
    logic [5:0]  iv_cnt;
    logic [4:0]  pass_cnt;
    logic [4:0]  checks_needed;
    logic        demod_q;
    logic        edge_seen;
    logic        forced;
    logic        permanent;
    logic        sleep_done;
    logic        warm_done;
    logic        too_short;
    logic        too_long;
    logic        all_passed;

    assign stretch = long_idle_select_bit_i ? 4'(pbc_pkg::STRETCH_LONG)
                                            : 4'(pbc_pkg::STRETCH_SHORT);
    assign sleep_target = 18'({idle_setting_i, 10'h000}) * 18'(stretch);
    assign forced       = !force_receive_n_i;
    assign permanent    = (idle_setting_i == pbc_pkg::IDLE_PERMANENT);
    assign sleep_done   = forced || (!permanent && base_tick && (sleep_cnt + 18'h1 >= sleep_target));
    assign warm_done    = base_tick && (warm_cnt == 16'(WARMUP - 1));
    assign checks_needed = forced ? 5'h0 : 5'(6 * verified_bits_i);
    assign edge_seen  = (demod_i != demod_q);
    // Edges only count on extended ticks, so short glitches between ticks are ignored
    assign too_short  = ext_tick && edge_seen && (iv_cnt < {1'b0, low_bound_i});
    assign too_long   = (iv_cnt >= {1'b0, high_bound_i});
    assign all_passed = (pass_cnt >= checks_needed);

    always_comb begin
        next_state = state;
        unique case (state)
            pbc_pkg::PBC_SLEEP:  if (sleep_done) next_state = pbc_pkg::PBC_WARMUP;
            pbc_pkg::PBC_WARMUP: if (warm_done)  next_state = pbc_pkg::PBC_CHECK;
            pbc_pkg::PBC_CHECK: begin
                if (all_passed) begin
                    next_state = pbc_pkg::PBC_RECV;
                end else if (too_short || too_long) begin
                    next_state = pbc_pkg::PBC_SLEEP;
                end
            end
            pbc_pkg::PBC_RECV: if (return_to_polling_i) next_state = pbc_pkg::PBC_SLEEP;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state <= pbc_pkg::PBC_SLEEP;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock_i) begin
        // Held at zero in permanent sleep so a new setting gets a full period
        if (sys_rst_i || state != pbc_pkg::PBC_SLEEP || permanent) begin
            sleep_cnt <= 18'h0;
        end else if (base_tick) begin
            sleep_cnt <= sleep_cnt + 18'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || state != pbc_pkg::PBC_WARMUP) begin
            warm_cnt <= 16'h0;
        end else if (base_tick) begin
            warm_cnt <= warm_cnt + 16'h1;
        end
    end

    // Demodulated level is sampled every clock outside PBC_CHECK, and on extended ticks only in PBC_CHECK
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            demod_q <= 1'b1;
        end else if (state != pbc_pkg::PBC_CHECK) begin
            demod_q <= demod_i;
        end else if (ext_tick) begin
            demod_q <= demod_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || state != pbc_pkg::PBC_CHECK) begin
            iv_cnt <= 6'h0;
        end else if (ext_tick) begin
            iv_cnt <= edge_seen ? 6'h1 : iv_cnt + 6'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || state == pbc_pkg::PBC_SLEEP) begin
            pass_cnt <= 5'h0;
        end else if (state == pbc_pkg::PBC_CHECK && ext_tick && edge_seen && !too_short) begin
            pass_cnt <= pass_cnt + 5'h1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            processing_en_o       <= 1'b0;
            receiver_awake_flag_o <= 1'b0;
            receive_mode_o        <= 1'b0;
            data_o                <= 1'b1;
        end else begin
            processing_en_o       <= (next_state != pbc_pkg::PBC_SLEEP);
            receiver_awake_flag_o <= (next_state != pbc_pkg::PBC_SLEEP);
            receive_mode_o        <= (next_state == pbc_pkg::PBC_RECV);
            data_o                <= (next_state == pbc_pkg::PBC_RECV) ? demod_i : 1'b1;
        end
    end

endmodule // pbc_controller

// File: tb/pbc_checker.sv
// Port-level properties of the polling bit-check controller.
// Assumes it is bound into pbc_controller; one clock domain.
`timescale 1ns/1ps

module pbc_checker (
    input wire logic       clock_i,
    input wire logic       sys_rst_i,
    input wire logic [4:0] idle_setting_i,
    input wire logic       force_receive_n_i,
    input wire logic       return_to_polling_i,
    input wire logic       demod_i,
    input wire logic       data_o,
    input wire logic       processing_en_o,
    input wire logic       receiver_awake_flag_o,
    input wire logic       receive_mode_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_rx2; receive_mode_o ##1 receive_mode_o; endsequence
    sequence s_sleep2; !receive_mode_o ##1 !receive_mode_o; endsequence
    property p_en; processing_en_o == receiver_awake_flag_o; endproperty
    a_en: assert property (p_en) else $error("enable differs from flag");
    property p_route; s_rx2 |-> data_o == $past(demod_i); endproperty
    a_route: assert property (p_route) else $error("data not routed");
    property p_idle; s_sleep2 |-> data_o; endproperty
    a_idle: assert property (p_idle) else $error("data moved outside receive");
    property p_hold; receive_mode_o && !return_to_polling_i |=> receive_mode_o; endproperty
    a_hold: assert property (p_hold) else $error("receive dropped");
    property p_leave; receive_mode_o && return_to_polling_i |=> !receiver_awake_flag_o; endproperty
    a_leave: assert property (p_leave) else $error("receive not left");
    property p_perm;
        !receiver_awake_flag_o && idle_setting_i == 5'h1F && force_receive_n_i
            |=> !receiver_awake_flag_o;
    endproperty
    a_perm: assert property (p_perm) else $error("woke from permanent sleep");
    property p_force;
        !receiver_awake_flag_o && !force_receive_n_i |-> ##[1:60] receiver_awake_flag_o;
    endproperty
    a_force: assert property (p_force) else $error("force did not wake");
    property p_entry; $rose(receive_mode_o) |-> $past(receiver_awake_flag_o); endproperty
    a_entry: assert property (p_entry) else $error("receive straight from sleep");
endmodule // pbc_checker

// File: tb/pbc_host.sv
// Host-side model: drives the demodulated stream with a fixed edge spacing.
// Assumes the bench sets the spacing in clock cycles before raising run_i.
`timescale 1ns/1ps

module pbc_host (
    input  wire logic clock_i,
    input  wire logic run_i,
    input  wire logic [31:0] half_i,
    output logic      demod_o
);
    int cnt = 0;
    initial demod_o = 1'b1;
    always @(posedge clock_i) begin
        cnt <= (run_i && cnt + 1 < half_i) ? cnt + 1 : 0;
        if (run_i && cnt + 1 >= half_i) demod_o <= !demod_o;
    end
endmodule // pbc_host

// File: tb/pbc_controller_bench.sv
// Bench: wake, edge-window checks, forced receive, sleep timing, against a small model.
// Assumes pbc_pkg, pbc_controller, pbc_host and pbc_checker are compiled.
`timescale 1ns/1ps

module pbc_controller_bench;
    localparam int DIV = pbc_pkg::DIV_RATIO_A;
    logic       clock_i = 0, sys_rst_i = 1, long_i = 0, fn = 1, ret = 0, run = 0;
    logic [4:0] idle = 5'h1F, lo = 5'h0A, hi = 5'h14;
    logic [1:0] br = 2'h0, vb = 2'h0;
    logic       demod, data, en, awake, rx;
    int         half = 1, fail_count = 0, n_tests = 0;

    pbc_controller #(.DIV_RATIO(DIV), .WARMUP(2)) pbc_controller_i (.clock_i, .sys_rst_i,
        .idle_setting_i(idle), .long_idle_select_bit_i(long_i), .baud_range_select_i(br),
        .verified_bits_i(vb), .low_bound_i(lo), .high_bound_i(hi), .force_receive_n_i(fn),
        .return_to_polling_i(ret), .demod_i(demod), .data_o(data), .processing_en_o(en),
        .receiver_awake_flag_o(awake), .receive_mode_o(rx));
    pbc_host pbc_host_i (.clock_i, .run_i(run), .half_i(half), .demod_o(demod));

    initial forever #12.5 clock_i = !clock_i;

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic check(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Zero checks always pass; otherwise every interval must sit in the window
    function automatic logic model(int v, int n);
        return v == 0 || (n >= lo && n < hi);
    endfunction

    initial begin
        int n, xt, k;
        void'($urandom(30947));
        cyc(12);
        sys_rst_i <= 0;
        for (int i = 0; i < 6; i++) begin
            n = (i % 2 == 0) ? 15 : ($urandom_range(1) ? 5 : 25);
            xt = (i % 3 == 0) ? 4 : (i % 3 == 1) ? 2 : 1;
            cyc(1);
            br <= 2'(i % 3);
            vb <= 2'(i % 4);
            long_i <= 1'($urandom);
            half <= n * xt * DIV;
            idle <= 5'h00;
            k = 0;
            while (!awake && k < 200) begin
                cyc(1);
                k++;
            end
            check(awake, 1'b1, "no wake from zero idle");
            idle <= 5'h1F;
            run <= 1;
            k = 0;
            while (awake && !rx && k < 40000) begin
                cyc(1);
                k++;
            end
            check(awake, rx, "validation did not end");
            check(rx, model(i % 4, n), "receive entry");
            run <= 0;
            ret <= rx;
            cyc(1);
            ret <= 0;
            cyc(3000);
            check(awake, 1'b0, "permanent sleep");
            $display("test %0d done", i);
        end
        fn <= 0;
        k = 0;
        while (!rx && k < 400) begin
            cyc(1);
            k++;
        end
        check(rx, 1'b1, "forced receive");
        fn <= 1;
        cyc(2);
        ret <= 1;
        cyc(1);
        ret <= 0;
        cyc(3);
        check(rx, 1'b0, "return to polling");
        $display("force test done");
        // Sleep length with stretch 1, then stretch 8 cut short by stretch 1
        idle <= 5'h01;
        long_i <= 1'b0;
        cyc(1020 * DIV);
        check(awake, 1'b0, "woke before idle time");
        k = 0;
        while (!awake && k < 8 * DIV) begin
            cyc(1);
            k++;
        end
        check(awake, 1'b1, "idle time overrun");
        idle <= 5'h1F;
        k = 0;
        while (awake && !rx && k < 2000) begin
            cyc(1);
            k++;
        end
        check(awake, 1'b0, "edgeless check not failed");
        idle <= 5'h01;
        long_i <= 1'b1;
        cyc(1030 * DIV);
        check(awake, 1'b0, "stretch 8 ignored");
        long_i <= 1'b0;
        k = 0;
        while (!awake && k < 4 * DIV) begin
            cyc(1);
            k++;
        end
        check(awake, 1'b1, "stretch 1 not restored");
        idle <= 5'h1F;
        $display("sleep test done");
        test_done();
    end

    initial begin
        cyc(100000);
        fail_count++;
        test_done();
    end
endmodule // pbc_controller_bench

bind pbc_controller pbc_checker pbc_checker_i (.*);
